// >>> hdl/led_prog_defs.svh
`ifndef LED_PROG_DEFS_SVH
`define LED_PROG_DEFS_SVH

// widths of the level code, burst counter, millivolt output and run timer
`define LEVEL_W 4
`define CNT_W 5
`define MV_W 10
`define TIMER_W 24

// number of level states and the saturation point of the burst counter
`define LEVEL_STATES 5'h10

// reference clock rate in MHz (period 5 ns)
`define REF_CLK_MHZ 200

// latch hold time and shutdown low time in microseconds
`define LATCH_HOLD_US 500
`define SHUTDOWN_LOW_US 1000

// feedback reference table, in millivolts
`define FB_LO_BASE_MV 10'h064
`define FB_HI_BASE_MV 10'h12C
`define FB_STEP_MV 10'h014
`define FB_SPAN_MV 10'h12C
`define FB_MAX_MV 10'h258

// level code after power-up or disable: table default and the alternative reading
`define TABLE_DEFAULT_CODE 4'h0
`define TEXT_DEFAULT_CODE 4'hF

`endif

// >>> hdl/led_prog_pkg.sv
package led_prog_pkg;

	// link state, Gray coded along off -> burst -> hold
	typedef enum logic [1:0]
	{
		ST_OFF = 2'b00,
		ST_BURST = 2'b01,
		ST_HOLD = 2'b11
	} link_state_t;

	// four-bit level code, edge count minus one
	typedef logic [3:0] level_code_t;

	// feedback reference expressed in millivolts
	typedef logic [9:0] millivolt_t;

endpackage : led_prog_pkg

// >>> hdl/level_to_millivolts.sv
`timescale 1ns/1ps
`default_nettype none
`include "led_prog_defs.svh"

module level_to_millivolts
#(
	parameter bit DESCENDING = 1'b0
)
(
	// level code and range select
	input wire led_prog_pkg::level_code_t code,
	input wire logic range_hi,
	// resulting feedback reference
	output logic [9:0] mv
);
	import led_prog_pkg::*;

	// step offset of this code above the range base
	logic [9:0] step_off;
	// base of the selected range
	logic [9:0] base;

	assign step_off = `FB_STEP_MV * {6'h00, code};
	assign base = range_hi ? `FB_HI_BASE_MV : `FB_LO_BASE_MV;

	// linear table, rising or falling by variant
	always_comb
	begin
		if (DESCENDING)
			mv = base + `FB_SPAN_MV - step_off;
		else
			mv = base + step_off;
	end

endmodule : level_to_millivolts
`default_nettype wire

// >>> hdl/pulse_count_led_level_prog.sv
`timescale 1ns/1ps
`default_nettype none
`include "led_prog_defs.svh"

module pulse_count_led_level_prog
#(
	// variant: 0 ascending table, 1 descending table
	parameter bit DESCENDING = 1'b0,
	// 1 takes the code F default reading (0.6 V / 0.4 V on the ascending table) instead of the table default
	parameter bit TEXT_DEFAULT = 1'b0,
	// latch hold and shutdown low times in clock cycles
	parameter int LATCH_CYCLES = `LATCH_HOLD_US * `REF_CLK_MHZ,
	parameter int SHUTDOWN_CYCLES = `SHUTDOWN_LOW_US * `REF_CLK_MHZ
)
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RESET_N,
	// pins from the host
	input wire logic EN_SET,
	input wire logic RANGE_SEL,
	// programmed result
	output led_prog_pkg::millivolt_t FEEDBACK_REFERENCE_MV,
	output led_prog_pkg::level_code_t LEVEL_CODE,
	output logic DEVICE_ENABLED
);
	import led_prog_pkg::*;

	// default level code for this variant
	function automatic level_code_t default_code(input bit text_rd);
		default_code = text_rd ? `TEXT_DEFAULT_CODE : `TABLE_DEFAULT_CODE;
	endfunction : default_code

	// both pins arrive from outside, gathered for the synchroniser loop
	logic [1:0] pin_in;
	// filtered levels of the pins
	logic en_lvl;
	logic sel_lvl;
	// agreed edges of the enable/set line
	logic en_rise;
	logic en_fall;
	// link state
	link_state_t state;
	// edges counted in the current burst
	logic [4:0] burst_cnt;
	// committed level code
	level_code_t level;
	// cycles since the enable/set level last changed
	logic [23:0] run;
	// latch and shutdown events
	logic latch_now;
	logic shutdown_now;
	// both range values of the current level
	millivolt_t mv_lo;
	millivolt_t mv_hi;
	// feedback output register
	millivolt_t fb_mv;

	assign pin_in = {RANGE_SEL, EN_SET};

	// three-stage synchronisers; a level counts once stages two and three agree
	genvar g;
	for (g = 0; g < 2; g++)
	begin : g_sync
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
		always_ff @(posedge REF_CLK)
		begin
			if (!RESET_N)
			begin
				s1 <= 1'b0;
				s2 <= 1'b0;
				s3 <= 1'b0;
				lvl <= 1'b0;
			end
			else
			begin
				s1 <= pin_in[g];
				s2 <= s1;
				s3 <= s2;
				if (s2 == s3)
					lvl <= s3;
			end
		end
	end

	assign en_lvl = g_sync[0].lvl;
	assign sel_lvl = g_sync[1].lvl;
	// 1MHz pulses last 100 cycles, far above the 3-cycle delay from pin change to agreed edge
	assign en_rise = !en_lvl && g_sync[0].s2 && g_sync[0].s3;
	assign en_fall = en_lvl && !g_sync[0].s2 && !g_sync[0].s3;

	// timer restarts on every agreed edge and sticks at its top
	always_ff @(posedge REF_CLK)
	begin
		if (!RESET_N)
			run <= 24'h000000;
		else if (en_rise || en_fall)
			run <= 24'h000000;
		else if (run != 24'hFFFFFF)
			run <= run + 24'h000001;
	end

	// host keeps the line high for the latch time to commit
	assign latch_now = (state == ST_BURST) && en_lvl && (run == 24'(LATCH_CYCLES - 1));
	// low longer than the shutdown time; shutdown must exceed latch
	assign shutdown_now = (state != ST_OFF) && !en_lvl && (run == 24'(SHUTDOWN_CYCLES - 1));

	// link state: any rising edge outside the shutdown cycle opens or extends a burst
	always_ff @(posedge REF_CLK)
	begin
		if (!RESET_N)
			state <= ST_OFF;
		else if (shutdown_now)
			state <= ST_OFF;
		else if (en_rise)
			state <= ST_BURST;
		else if (latch_now)
			state <= ST_HOLD;
	end

	// burst counter, first edge of a burst counts one, saturating at sixteen
	always_ff @(posedge REF_CLK)
	begin
		if (!RESET_N)
			burst_cnt <= 5'h00;
		else if (shutdown_now)
			burst_cnt <= 5'h00;
		else if (en_rise && state != ST_BURST)
			burst_cnt <= 5'h01;
		else if (en_rise && burst_cnt != `LEVEL_STATES)
			burst_cnt <= burst_cnt + 5'h01;
		// extra edges stay at the last state
	end

	// committed level: default on power-up and on disable, count minus one on latch
	always_ff @(posedge REF_CLK)
	begin
		if (!RESET_N)
			level <= default_code(TEXT_DEFAULT);
		else if (shutdown_now)
			level <= default_code(TEXT_DEFAULT);
		else if (latch_now)
			level <= 4'(burst_cnt - 5'h01);
	end

	// both ranges mapped so the range pin changes the output without reprogramming
	level_to_millivolts #(.DESCENDING(DESCENDING)) u_map_lo
	(
		.code(level),
		.range_hi(1'b0),
		.mv(mv_lo)
	);
	level_to_millivolts #(.DESCENDING(DESCENDING)) u_map_hi
	(
		.code(level),
		.range_hi(1'b1),
		.mv(mv_hi)
	);

	// registered reference; range pin selects the table half, ratio set by level
	always_ff @(posedge REF_CLK)
	begin
		if (!RESET_N)
			fb_mv <= 10'h000;
		else
			fb_mv <= sel_lvl ? mv_hi : mv_lo;
	end

	assign FEEDBACK_REFERENCE_MV = fb_mv;
	assign LEVEL_CODE = level;
	assign DEVICE_ENABLED = (state != ST_OFF);

	// counter never passes sixteen
	chk_count_saturates: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		burst_cnt <= `LEVEL_STATES)
		else $error("burst counter passed sixteen");

	// each edge within a burst below sixteen adds one
	chk_edge_counts: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		en_rise && state == ST_BURST && burst_cnt < `LEVEL_STATES && !shutdown_now
		|=> burst_cnt == $past(burst_cnt) + 5'h01)
		else $error("rising edge not counted");

	// latch stores count minus one and leaves the burst
	chk_latch_commit: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		latch_now && !en_fall |=> level == 4'($past(burst_cnt) - 5'h01) && state == ST_HOLD)
		else $error("latched level differs from count");

	// long low disables and restores the default
	chk_shutdown_default: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		shutdown_now |=> state == ST_OFF && level == default_code(TEXT_DEFAULT) && !DEVICE_ENABLED)
		else $error("shutdown did not restore default");

	// output matches the table once level and range held one edge; skips the edge after reset
	chk_fb_follows: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		$past(RESET_N) && $stable(level) && $stable(sel_lvl)
		|-> fb_mv == (sel_lvl ? `FB_HI_BASE_MV : `FB_LO_BASE_MV)
		+ (DESCENDING ? `FB_SPAN_MV - `FB_STEP_MV * {6'h00, level} : `FB_STEP_MV * {6'h00, level}))
		else $error("feedback output stale");

	// high range always 0.2 V above the low range
	chk_sel_raises: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		mv_hi == mv_lo + 10'h0C8)
		else $error("range select does not raise reference");

	// table bounds 0.1 V to 0.6 V in 20 mV steps
	chk_table_bounds: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		mv_lo >= `FB_LO_BASE_MV && mv_hi <= `FB_MAX_MV
		&& mv_lo == (DESCENDING ? 10'h190 - `FB_STEP_MV * {6'h00, level} : 10'h064 + `FB_STEP_MV * {6'h00, level}))
		else $error("reference outside table");

	// ratio 3.0x at the ascending table default, 1.5x at the descending one
	chk_default_ratio: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
		level == `TABLE_DEFAULT_CODE
		|-> (DESCENDING ? (2 * mv_hi == 3 * mv_lo) : (mv_hi == 3 * mv_lo)))
		else $error("default range ratio wrong");

	// power-up begins disabled at the default level
	chk_reset_default: assert property (@(posedge REF_CLK)
		!RESET_N |=> level == default_code(TEXT_DEFAULT) && state == ST_OFF)
		else $error("reset did not load default level");

endmodule : pulse_count_led_level_prog
`default_nettype wire

// >>> verification/host_link.sv
`timescale 1ns/1ps
`default_nettype none

module host_link
(
	// clock of the bench
	input wire logic clk,
	// enable/set line to the device
	output logic en_set
);
	// line rests low until the first burst
	initial en_set = 1'b0;

	// n rising edges at 100-cycle phases (1 MHz), the last high held for hold cycles
	task automatic burst(input int n, input int hold);
		for (int i = 0; i < n; i++)
		begin
			en_set = 1'b0;
			repeat (100) @(negedge clk);
			en_set = 1'b1;
			repeat ((i == n - 1) ? hold : 100) @(negedge clk);
		end
	endtask : burst

	// line held low for c cycles
	task automatic rest(input int c);
		en_set = 1'b0;
		repeat (c) @(negedge clk);
	endtask : rest
endmodule : host_link

`default_nettype wire

// >>> verification/pulse_count_led_level_prog_bench.sv
`timescale 1ns/1ps
`default_nettype none

module pulse_count_led_level_prog_bench;
	import led_prog_pkg::*;
	// short times keep the run brief; shutdown stays longer than latch
	localparam int LAT = 400;
	localparam int OFF = 800;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic range_sel = 1'b0;
	wire logic en_set;
	millivolt_t mv_a, mv_d, mv_t;
	level_code_t code_a, code_d, code_t;
	logic on_a, on_d, on_t;
	int error_cnt = 0;
	int num_checks = 0;
	int cur = 0;
	// expected code of the instance that takes the alternative default (code F)
	int cur_t = 15;

	// 200 MHz clock
	always #2.5 ref_clk = ~ref_clk;

	host_link u_host (.clk(ref_clk), .en_set(en_set));
	// ascending and descending variants share the pins
	pulse_count_led_level_prog #(.DESCENDING(1'b0), .LATCH_CYCLES(LAT), .SHUTDOWN_CYCLES(OFF)) u_dut
		(.REF_CLK(ref_clk), .RESET_N(reset_n), .EN_SET(en_set), .RANGE_SEL(range_sel),
		.FEEDBACK_REFERENCE_MV(mv_a), .LEVEL_CODE(code_a), .DEVICE_ENABLED(on_a));
	pulse_count_led_level_prog #(.DESCENDING(1'b1), .LATCH_CYCLES(LAT), .SHUTDOWN_CYCLES(OFF)) u_dut_desc
		(.REF_CLK(ref_clk), .RESET_N(reset_n), .EN_SET(en_set), .RANGE_SEL(range_sel),
		.FEEDBACK_REFERENCE_MV(mv_d), .LEVEL_CODE(code_d), .DEVICE_ENABLED(on_d));
	// ascending variant with the alternative default reading
	pulse_count_led_level_prog #(.DESCENDING(1'b0), .TEXT_DEFAULT(1'b1), .LATCH_CYCLES(LAT),
		.SHUTDOWN_CYCLES(OFF)) u_dut_text
		(.REF_CLK(ref_clk), .RESET_N(reset_n), .EN_SET(en_set), .RANGE_SEL(range_sel),
		.FEEDBACK_REFERENCE_MV(mv_t), .LEVEL_CODE(code_t), .DEVICE_ENABLED(on_t));

	// one compare, counted
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// both variants at code k, the alternative-default instance at cur_t, enable state on
	task automatic check_all(input int k, input logic on);
		logic [9:0] hi;
		hi = range_sel ? 10'h0C8 : 10'h000;
		chk({6'h00, code_a}, k[9:0]);
		chk({6'h00, code_d}, k[9:0]);
		chk(mv_a, 10'h064 + 10'h014 * k[9:0] + hi);
		chk(mv_d, 10'h190 - 10'h014 * k[9:0] + hi);
		chk({9'h000, on_a}, {9'h000, on});
		chk({9'h000, on_d}, {9'h000, on});
		chk({6'h00, code_t}, cur_t[9:0]);
		chk(mv_t, 10'h064 + 10'h014 * cur_t[9:0] + hi);
		chk({9'h000, on_t}, {9'h000, on});
	endtask : check_all

	// burst of n: nothing commits before the latch time, then code n-1 saturated
	task automatic program_level(input int n);
		u_host.burst(n, LAT - 10);
		check_all(cur, 1'b1);
		repeat (20) @(negedge ref_clk);
		cur = (n > 16) ? 15 : n - 1;
		cur_t = cur;
		check_all(cur, 1'b1);
	endtask : program_level

	// range select raises the reference without reprogramming, and falls back
	task automatic range_step;
		range_sel = 1'b1;
		repeat (6) @(negedge ref_clk);
		check_all(cur, 1'b1);
		range_sel = 1'b0;
		repeat (6) @(negedge ref_clk);
		check_all(cur, 1'b1);
	endtask : range_step

	// long low disables and restores the default code
	task automatic shutdown;
		u_host.rest(OFF + 20);
		cur = 0;
		cur_t = 15;
		check_all(0, 1'b0);
	endtask : shutdown

	// verdict and end of run
	task automatic test_done;
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done

	// main sequence, driven on falling edges
	initial
	begin
		repeat (8) @(negedge ref_clk);
		reset_n = 1'b1;
		repeat (2) @(negedge ref_clk);
		check_all(0, 1'b0);
		program_level(1);
		program_level(5);
		range_step();
		program_level(16);
		range_step();
		program_level(20);
		shutdown();
		program_level(2);
		test_done();
	end

	// hang guard
	initial
	begin
		repeat (100000) @(posedge ref_clk);
		error_cnt++;
		test_done();
	end
endmodule : pulse_count_led_level_prog_bench

`default_nettype wire
